//--- rtl/suop_unit.sv
`timescale 1ns/1ps
`include "suop_cfg.svh"

// Overview of operation
// - Dual-form operators pick prefix behaviour before the variable, suffix after.
// - Post-clear returns the old value, then writes all zeros back.
// - Word sign extend copies bit 15 into bits 16 to 31.
// - Post-set returns the old value, then writes all ones back.
// - Sign extends and post writes always write back the variable.
// - Arithmetic right shift fills vacated high bits with the original bit 31.
// - Assignment shift takes the variable and writes the shifted value back.
// - Random step is a 32-bit maximal four-tap lfsr, taps at msb and lsb.
// - Random step is deterministic: same seed gives the same sequence.
// - Prefix random replaces the variable with its forward successor.
// - Suffix random steps backward, exactly inverting the forward step.
// - Decode turns index 0 to 31 into a one-hot 32-bit word.
// - Encode returns highest set bit position plus one, 0 to 32.
// - Encode of an all-zero operand returns zero.
// - Standalone decode writes the decoded word back into the variable.
module suop_unit (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire suop_pkg::suop_op_t op_sel,
    input wire suop_pkg::suop_form_t op_form,
    input wire logic op_standalone,
    input wire logic [`SUOP_WIDTH-1:0] operand,
    input wire logic [`SUOP_WIDTH-1:0] shift_count,
    output logic res_valid,
    output logic [`SUOP_WIDTH-1:0] result,
    output logic wb_en,
    output logic [`SUOP_WIDTH-1:0] wb_value
);
    import suop_pkg::*;

    logic [`SUOP_WIDTH-1:0] rand_step;
    logic [`SUOP_ENC_BITS-1:0] enc_code;
    logic [`SUOP_CNT_BITS-1:0] sh_amt;
    logic [`SUOP_WIDTH-1:0] sar_val;
    logic [`SUOP_WIDTH-1:0] dec_val;

    logic res_valid_reg, res_valid_next;
    logic [`SUOP_WIDTH-1:0] result_reg, result_next;
    logic wb_en_reg, wb_en_next;
    logic [`SUOP_WIDTH-1:0] wb_value_reg, wb_value_next;

    // -------------------------------------------------------------
    // shared datapath pieces
    // -------------------------------------------------------------
    // the lfsr is pure combinational logic on the operand and form, so a seed always maps to one value per direction
    suop_lfsr_step u_lfsr (
        .seed(operand),
        .reverse(op_form == SUOP_FORM_SUFFIX),
        .step(rand_step)
    );

    suop_msb_encode u_enc (
        .value(operand),
        .code(enc_code)
    );

    // count and index truncate to five bits, so every input has a defined answer
    assign sh_amt = shift_count[`SUOP_CNT_BITS-1:0];
    assign sar_val = $unsigned($signed(operand) >>> sh_amt);
    assign dec_val = `SUOP_WIDTH'(1) << operand[`SUOP_CNT_BITS-1:0];

    // -------------------------------------------------------------
    // operator select
    // -------------------------------------------------------------
    // result goes to the expression, wb_value to the variable; both land in the same cycle
    always_comb begin
        res_valid_next = op_valid;
        result_next = result_reg;
        wb_en_next = 1'b0;
        wb_value_next = wb_value_reg;
        if (op_valid) begin
            case (op_sel)
                SUOP_OP_TILDE: begin
                    wb_en_next = 1'b1;
                    if (op_form == SUOP_FORM_PREFIX) begin
                        result_next = {{(`SUOP_MSB-`SUOP_BYTE_SIGN_BIT){operand[`SUOP_BYTE_SIGN_BIT]}},
                                       operand[`SUOP_BYTE_SIGN_BIT:0]};
                        wb_value_next = result_next;
                    end else begin
                        result_next = operand;
                        wb_value_next = `SUOP_ALL_ZERO;
                    end
                end
                SUOP_OP_DTILDE: begin
                    wb_en_next = 1'b1;
                    if (op_form == SUOP_FORM_PREFIX) begin
                        result_next = {{(`SUOP_MSB-`SUOP_WORD_SIGN_BIT){operand[`SUOP_WORD_SIGN_BIT]}},
                                       operand[`SUOP_WORD_SIGN_BIT:0]};
                        wb_value_next = result_next;
                    end else begin
                        result_next = operand;
                        wb_value_next = `SUOP_ALL_ONES;
                    end
                end
                SUOP_OP_SAR: begin
                    result_next = sar_val;
                end
                SUOP_OP_SAR_ASG: begin
                    result_next = sar_val;
                    wb_en_next = 1'b1;
                    wb_value_next = sar_val;
                end
                SUOP_OP_RAND: begin
                    // direction follows the form; the step itself lives in the lfsr module
                    result_next = rand_step;
                    wb_en_next = 1'b1;
                    wb_value_next = rand_step;
                end
                SUOP_OP_DECODE: begin
                    result_next = dec_val;
                    // only a bare statement turns decode into an assignment
                    wb_en_next = op_standalone;
                    wb_value_next = dec_val;
                end
                SUOP_OP_ENCODE: begin
                    result_next = {{(`SUOP_WIDTH-`SUOP_ENC_BITS){1'b0}}, enc_code};
                end
                default: begin
                    result_next = result_reg;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // output registers
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_valid_reg <= 1'b0;
            result_reg <= `SUOP_RESULT_RST;
            wb_en_reg <= 1'b0;
            wb_value_reg <= `SUOP_RESULT_RST;
        end else begin
            res_valid_reg <= res_valid_next;
            result_reg <= result_next;
            wb_en_reg <= wb_en_next;
            wb_value_reg <= wb_value_next;
        end
    end

    assign res_valid = res_valid_reg;
    assign result = result_reg;
    assign wb_en = wb_en_reg;
    assign wb_value = wb_value_reg;
endmodule // suop_unit

//--- include/suop_cfg.svh
`ifndef SUOP_CFG_SVH
`define SUOP_CFG_SVH

// -------------------------------------------------------------
// operand geometry
// -------------------------------------------------------------
`define SUOP_WIDTH 32
`define SUOP_BYTE_SIGN_BIT 7
`define SUOP_WORD_SIGN_BIT 15
`define SUOP_MSB 31
`define SUOP_CNT_BITS 5
`define SUOP_ENC_BITS 6

// -------------------------------------------------------------
// lfsr taps (bit positions of the feedback polynomial)
// -------------------------------------------------------------
`define SUOP_TAP_A 31
`define SUOP_TAP_B 21
`define SUOP_TAP_C 1
`define SUOP_TAP_D 0

// -------------------------------------------------------------
// reset and post write values
// -------------------------------------------------------------
`define SUOP_RESULT_RST 32'h0000_0000
`define SUOP_ALL_ONES 32'hFFFF_FFFF
`define SUOP_ALL_ZERO 32'h0000_0000

`endif

//--- include/suop_pkg.sv
package suop_pkg;

    // operator selection presented by the sequencer
    typedef enum logic [2:0] {
        SUOP_OP_TILDE,   // byte sign extend (prefix) / post-clear (suffix)
        SUOP_OP_DTILDE,  // word sign extend (prefix) / post-set (suffix)
        SUOP_OP_SAR,     // arithmetic right shift
        SUOP_OP_SAR_ASG, // arithmetic right shift, assignment form
        SUOP_OP_RAND,    // random step, forward (prefix) / reverse (suffix)
        SUOP_OP_DECODE,  // one-hot decode
        SUOP_OP_ENCODE   // highest set bit plus one
    } suop_op_t;

    // side of the variable on which the operator stands
    typedef enum logic {
        SUOP_FORM_PREFIX,
        SUOP_FORM_SUFFIX
    } suop_form_t;

endpackage

//--- rtl/suop_lfsr_step.sv
`timescale 1ns/1ps
`include "suop_cfg.svh"

// one combinational step of the reversible lfsr, either direction
module suop_lfsr_step (
    input wire logic [`SUOP_WIDTH-1:0] seed,
    input wire logic reverse,
    output logic [`SUOP_WIDTH-1:0] step
);
    logic fwd_bit;
    logic rev_bit;

    // -------------------------------------------------------------
    // feedback
    // -------------------------------------------------------------
    // forward shifts left and feeds bit 0; reverse shifts right and rebuilds the lost msb,
    // which works only because the msb is a tap
    always_comb begin
        fwd_bit = seed[`SUOP_TAP_A] ^ seed[`SUOP_TAP_B] ^ seed[`SUOP_TAP_C] ^ seed[`SUOP_TAP_D];
        rev_bit = seed[0] ^ seed[`SUOP_TAP_B+1] ^ seed[`SUOP_TAP_C+1] ^ seed[`SUOP_TAP_D+1];
        if (reverse) begin
            step = {rev_bit, seed[`SUOP_WIDTH-1:1]};
        end else begin
            step = {seed[`SUOP_WIDTH-2:0], fwd_bit};
        end
    end
endmodule // suop_lfsr_step

//--- rtl/suop_msb_encode.sv
`timescale 1ns/1ps
`include "suop_cfg.svh"

// position of the highest set bit plus one, zero when nothing is set
module suop_msb_encode (
    input wire logic [`SUOP_WIDTH-1:0] value,
    output logic [`SUOP_ENC_BITS-1:0] code
);
    // -------------------------------------------------------------
    // priority scan
    // -------------------------------------------------------------
    // low to high so the last hit is the highest bit
    always_comb begin
        code = '0;
        for (int i = 0; i < `SUOP_WIDTH; i++) begin
            if (value[i]) begin
                code = `SUOP_ENC_BITS'(i + 1);
            end
        end
    end
endmodule // suop_msb_encode

//--- verification/suop_unit_monitor.sv
`timescale 1ns/1ps
module suop_unit_monitor
import suop_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire suop_op_t op_sel,
    input wire suop_form_t op_form,
    input wire logic op_standalone,
    input wire logic [31:0] operand,
    input wire logic [31:0] shift_count,
    input wire logic res_valid,
    input wire logic [31:0] result,
    input wire logic wb_en,
    input wire logic [31:0] wb_value
);
// ----------------------------------------
// request shapes, answer one cycle later
// ----------------------------------------
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
sequence s_op(suop_op_t o);
    op_valid && op_sel == o;
endsequence
sequence s_suf(suop_op_t o);
    s_op(o) ##0 op_form == SUOP_FORM_SUFFIX;
endsequence
sequence s_pre(suop_op_t o);
    s_op(o) ##0 op_form == SUOP_FORM_PREFIX;
endsequence
property p_clr;
    s_suf(SUOP_OP_TILDE) |=> result == $past(operand) && wb_en && wb_value == 32'h0;
endproperty
property p_set;
    s_suf(SUOP_OP_DTILDE) |=> result == $past(operand) && wb_en && wb_value == 32'hFFFF_FFFF;
endproperty
property p_sx7;
    s_pre(SUOP_OP_TILDE) |=> result == {{24{$past(operand[7])}}, $past(operand[7:0])} && wb_value == result;
endproperty
property p_sx15;
    s_pre(SUOP_OP_DTILDE) |=> result == {{16{$past(operand[15])}}, $past(operand[15:0])} && wb_en;
endproperty
property p_sar;
    s_op(SUOP_OP_SAR) |=> result == 32'($signed($past(operand)) >>> $past(shift_count[4:0])) && !wb_en;
endproperty
property p_asg;
    s_op(SUOP_OP_SAR_ASG) |=> wb_en && wb_value == result;
endproperty
property p_dec;
    s_op(SUOP_OP_DECODE) |=> result == 32'h1 << $past(operand[4:0]) && wb_en == $past(op_standalone);
endproperty
property p_fwd;
    s_pre(SUOP_OP_RAND) |=> result == {$past(operand[30:0]), ^($past(operand) & 32'h8020_0003)};
endproperty
property p_rev;
    s_suf(SUOP_OP_RAND) |=> result == {^($past(operand) & 32'h0040_0007), $past(operand[31:1])};
endproperty
property p_enc0;
    s_op(SUOP_OP_ENCODE) ##0 operand == 32'h0 |=> result == 32'h0 && !wb_en;
endproperty
property p_idle;
    !op_valid |=> !res_valid && !wb_en;
endproperty
a_clr: assert property (p_clr) else $error("post clear wrong");
a_set: assert property (p_set) else $error("post set wrong");
a_sx7: assert property (p_sx7) else $error("byte extend wrong");
a_sx15: assert property (p_sx15) else $error("word extend wrong");
a_sar: assert property (p_sar) else $error("shift wrong");
a_asg: assert property (p_asg) else $error("shift write-back wrong");
a_dec: assert property (p_dec) else $error("decode wrong");
a_fwd: assert property (p_fwd) else $error("forward step wrong");
a_rev: assert property (p_rev) else $error("reverse step wrong");
a_enc0: assert property (p_enc0) else $error("encode of zero wrong");
a_idle: assert property (p_idle) else $error("answer without request");
endmodule // suop_unit_monitor
bind suop_unit suop_unit_monitor i_mon (.clk, .rst_n, .op_valid, .op_sel, .op_form, .op_standalone,
    .operand, .shift_count, .res_valid, .result, .wb_en, .wb_value);

//--- verification/suop_var_model.sv
`timescale 1ns/1ps
module suop_var_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_en,
    input wire logic [31:0] wb_value,
    output logic [31:0] var_reg
);
// the sequencer's variable; it changes only on a write-back or a reset, never on a result
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) var_reg <= 32'h0;
    else if (wb_en) var_reg <= wb_value;
end
endmodule // suop_var_model

//--- verification/suop_unit_bench.sv
`timescale 1ns/1ps
module suop_unit_bench;
import suop_pkg::*;
logic clk, rst_n, op_valid, op_standalone, res_valid, wb_en;
suop_op_t op_sel;
suop_form_t op_form;
logic [31:0] operand, shift_count, result, wb_value, var_reg, s[4];
int bad_count, n_checks;
suop_unit i_dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_sel(op_sel), .op_form(op_form),
    .op_standalone(op_standalone), .operand(operand), .shift_count(shift_count), .res_valid(res_valid),
    .result(result), .wb_en(wb_en), .wb_value(wb_value));
suop_var_model i_var (.clk(clk), .rst_n(rst_n), .wb_en(wb_en), .wb_value(wb_value), .var_reg(var_reg));
initial begin
    clk = 0;
    forever #25 clk = ~clk;
end
// ----------------------------------------
// shared helpers
// ----------------------------------------
task automatic chk_w(logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e) begin
        bad_count++;
        $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
endtask
task automatic chk_b(logic g, logic e);
    chk_w({31'h0, g}, {31'h0, e});
endtask
// one request, inputs moved 2 ns after the edge; answer read once it has landed
task automatic op(suop_op_t o, suop_form_t f, logic sa, logic [31:0] a, logic [31:0] c = 0);
    @(posedge clk) #2;
    op_valid = 1;
    op_sel = o;
    op_form = f;
    op_standalone = sa;
    operand = a;
    shift_count = c;
    @(posedge clk) #2;
    op_valid = 0;
    chk_b(res_valid, 1);
endtask
function automatic logic [31:0] fwd(logic [31:0] x);
    return {x[30:0], ^(x & 32'h8020_0003)};
endfunction
task automatic t_ext_post;
    op(SUOP_OP_TILDE, SUOP_FORM_PREFIX, 0, 32'h0000_0080);
    chk_w(result, 32'hFFFF_FF80);
    op(SUOP_OP_DTILDE, SUOP_FORM_PREFIX, 0, 32'h0000_FED4);
    chk_w(wb_value, 32'hFFFF_FED4);
    op(SUOP_OP_TILDE, SUOP_FORM_SUFFIX, 0, 32'h5);
    chk_w(var_reg, 32'hFFFF_FED4);
    chk_w(result, 32'h5);
    op(SUOP_OP_DTILDE, SUOP_FORM_SUFFIX, 0, 32'h6);
    chk_w(var_reg, 32'h0);
    chk_w(result, 32'h6);
    chk_w(wb_value, 32'hFFFF_FFFF);
    $display("test ext_post done");
endtask
task automatic t_shift;
    int c[4] = '{0, 4, 31, 33};
    logic [31:0] e[4] = '{32'h8070_FF35, 32'hF807_0FF3, 32'hFFFF_FFFF, 32'hC038_7F9A};
    foreach (c[i]) begin
        op(SUOP_OP_SAR, SUOP_FORM_PREFIX, 0, 32'h8070_FF35, c[i]);
        chk_w(result, e[i]);
        chk_b(wb_en, 0);
    end
    op(SUOP_OP_SAR_ASG, SUOP_FORM_PREFIX, 0, 32'hC000_0000, 2);
    chk_w(wb_value, 32'hF000_0000);
    $display("test shift done");
endtask
task automatic t_rand;
    s[0] = 32'h1234_5678;
    for (int r = 0; r < 2; r++) begin
        for (int i = 1; i < 4; i++) begin
            s[i] = fwd(s[i-1]);
            op(SUOP_OP_RAND, SUOP_FORM_PREFIX, 0, s[i-1]);
            chk_w(result, s[i]);
            chk_w(wb_value, s[i]);
        end
    end
    for (int i = 3; i > 0; i--) begin
        op(SUOP_OP_RAND, SUOP_FORM_SUFFIX, 0, s[i]);
        chk_w(result, s[i-1]);
    end
    $display("test rand done");
endtask
task automatic t_codes;
    logic [31:0] v[5] = '{32'h0, 32'h80, 32'h8000_0000, 32'h0013_1220, 32'h1};
    logic [31:0] e[5] = '{32'h0, 32'h8, 32'h20, 32'h15, 32'h1};
    logic [31:0] d[4] = '{32'h0, 32'h3, 32'h1F, 32'h63};
    logic [31:0] q[4] = '{32'h1, 32'h8, 32'h8000_0000, 32'h8};
    foreach (d[i]) begin
        op(SUOP_OP_DECODE, SUOP_FORM_PREFIX, d[i][0], d[i]);
        chk_w(result, q[i]);
        chk_b(wb_en, d[i][0]);
    end
    foreach (v[i]) begin
        op(SUOP_OP_ENCODE, SUOP_FORM_PREFIX, 0, v[i]);
        chk_w(result, e[i]);
    end
    $display("test codes done");
endtask
// reset in mid-run clears outputs and the variable; an unused code answers but writes nothing
task automatic t_reset;
    op(SUOP_OP_DTILDE, SUOP_FORM_SUFFIX, 0, 32'h7);
    @(posedge clk) #2;
    rst_n = 0;
    #1;
    chk_w(result, 32'h0);
    chk_w(wb_value, 32'h0);
    chk_b(res_valid, 0);
    chk_w(var_reg, 32'h0);
    repeat (2) @(posedge clk);
    #2 rst_n = 1;
    op(SUOP_OP_DTILDE, SUOP_FORM_SUFFIX, 0, 32'h7);
    chk_w(result, 32'h7);
    op(suop_op_t'(3'h7), SUOP_FORM_PREFIX, 0, 32'h1234);
    chk_w(result, 32'h7);
    chk_b(wb_en, 0);
    chk_w(wb_value, 32'hFFFF_FFFF);
    $display("test reset done");
endtask
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
// ----------------------------------------
// main sequence and watchdog
// ----------------------------------------
initial begin
    rst_n = 0;
    op_valid = 0;
    op_sel = SUOP_OP_TILDE;
    op_form = SUOP_FORM_PREFIX;
    op_standalone = 0;
    operand = '0;
    shift_count = '0;
    repeat (5) @(posedge clk);
    #2 rst_n = 1;
    t_ext_post;
    t_shift;
    t_rand;
    t_codes;
    t_reset;
    tally_and_finish;
end
initial begin
    #20000;
    bad_count++;
    tally_and_finish;
end
endmodule // suop_unit_bench
